/* rofs_pkg.sv */
// Behaviour
// - On link fault each channel holds its last level or takes its fault level
// - Fault level 0 drives the channel off, 1 drives it on
// - On Program mode each channel holds its last level or takes its program level
// - Program level 0 keeps the channel off, 1 on, until Program mode ends or link loss escalates to fault
// - Hold time 0 keeps the fault level forever, else that many seconds
// - After the hold time expires the channel drives its final level
// - Link loss in Program mode escalates to fault only when escalate is 1
// - Link-lost flag reads 0 while connected and 1 while not connected
package rofs_pkg;

   // ------------------------------------------------------------------
   // Sizes and timing
   // ------------------------------------------------------------------
   localparam int NUM_CH = 4;
   localparam int CLK_PERIOD_NS = 25;
   localparam int ONE_SECOND_NS = 1_000_000_000;
   localparam int CYCLES_PER_SEC = ONE_SECOND_NS / CLK_PERIOD_NS;
   localparam int PRESCALE_W = 26;

   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] HOLD_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

   // Control word field positions, one bit per channel in each field
   localparam int FAULT_SEL_POS = 0;
   localparam int FAULT_LVL_POS = 4;
   localparam int PROG_SEL_POS = 8;
   localparam int PROG_LVL_POS = 12;
   localparam int FINAL_LVL_POS = 16;
   localparam int ESCALATE_POS = 20;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // One byte of seconds per channel; 0 holds forever
   localparam logic [31:0] HOLD_RESET = 32'h0000_0000;

   // Status word positions
   localparam int STAT_LINK_POS = 0;
   localparam int STAT_STATE_POS = 4;
   localparam int STAT_RELAY_POS = 16;

   // Interrupt status and mask positions
   localparam int IRQ_LOST_POS = 0;
   localparam int IRQ_BACK_POS = 1;
   localparam int IRQ_EXPIRE_POS = 4;
   localparam logic [7:0] IRQ_RESET = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      CH_NORMAL = 2'h0,
      CH_FAULT = 2'h1,
      CH_FINAL = 2'h3,
      CH_PROGRAM = 2'h2
   } rofs_ch_state_t;

   typedef struct packed {
      logic [PRESCALE_W-1:0] prescale;
      logic [7:0] secs;
      logic active;
      logic expired;
   } rofs_timer_state_t;

   typedef struct packed {
      logic awtaken;
      logic [7:0] awaddr;
      logic wtaken;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ctrl;
      logic [31:0] hold;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      rofs_ch_state_t [NUM_CH-1:0] st;
      logic [NUM_CH-1:0] held;
      logic [NUM_CH-1:0] relay;
      logic link_lost;
   } rofs_state_t;

endpackage

/* rofs_hold_timer.sv */
`timescale 1ns/1ps
module rofs_hold_timer #(
   parameter int TICKS_PER_SEC = rofs_pkg::CYCLES_PER_SEC
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic start_i,
   input wire logic run_i,
   input wire logic [7:0] secs_i,
   output logic expired_o
);

   rofs_pkg::rofs_timer_state_t t_reg;
   rofs_pkg::rofs_timer_state_t t_next;

   localparam logic [rofs_pkg::PRESCALE_W-1:0] LAST_TICK =
      rofs_pkg::PRESCALE_W'(TICKS_PER_SEC - 1);

   always_comb begin
      t_next = t_reg;
      t_next.expired = 1'b0;
      if (start_i) begin
         // A zero setting never arms, so the fault level is held for good
         t_next.active = (secs_i != 8'h00);
         t_next.secs = secs_i;
         t_next.prescale = '0;
      end else if (!run_i) begin
         t_next.active = 1'b0;
      end else if (t_reg.active) begin
         if (t_reg.prescale == LAST_TICK) begin
            t_next.prescale = '0;
            t_next.secs = t_reg.secs - 8'h01;
            if (t_reg.secs == 8'h01) begin
               t_next.active = 1'b0;
               t_next.expired = 1'b1;
            end
         end else begin
            t_next.prescale = t_reg.prescale + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign expired_o = t_reg.expired;

endmodule

/* rofs_failsafe.sv */
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module rofs_failsafe #(
   parameter int TICKS_PER_SEC = rofs_pkg::CYCLES_PER_SEC
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Owner link, from network logic on this clock
   input wire logic link_up_i,
   input wire logic run_mode_i,
   input wire logic [3:0] out_data_i,
   output logic [3:0] relay_o,
   output logic link_lost_flag_o,
   output logic irq_o,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   rofs_pkg::rofs_state_t r_reg;
   rofs_pkg::rofs_state_t r_next;
   logic [3:0] start;
   logic [3:0] expired;
   logic [3:0] fault_action_select;
   logic [3:0] fault_output_level;
   logic [3:0] program_action_select;
   logic [3:0] program_output_level;
   logic [3:0] fault_final_level;
   logic [3:0] program_fault_escalate;

   assign fault_action_select = r_reg.ctrl[rofs_pkg::FAULT_SEL_POS +: 4];
   assign fault_output_level = r_reg.ctrl[rofs_pkg::FAULT_LVL_POS +: 4];
   assign program_action_select = r_reg.ctrl[rofs_pkg::PROG_SEL_POS +: 4];
   assign program_output_level = r_reg.ctrl[rofs_pkg::PROG_LVL_POS +: 4];
   assign fault_final_level = r_reg.ctrl[rofs_pkg::FINAL_LVL_POS +: 4];
   assign program_fault_escalate = r_reg.ctrl[rofs_pkg::ESCALATE_POS +: 4];

   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction

   // ------------------------------------------------------------------
   // Bus handshakes
   // ------------------------------------------------------------------
   assign s_axi_awready = !r_reg.awtaken && !r_reg.bvalid;
   assign s_axi_wready = !r_reg.wtaken && !r_reg.bvalid;
   assign s_axi_arready = !r_reg.rvalid;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic rd_clear;
      logic [7:0] ev;
      logic [31:0] status;
      r_next = r_reg;
      rd_clear = 1'b0;
      ev = 8'h00;
      start = 4'h0;
      status = 32'h0000_0000;

      status[rofs_pkg::STAT_LINK_POS] = r_reg.link_lost;
      status[rofs_pkg::STAT_RELAY_POS +: 4] = r_reg.relay;
      for (int i = 0; i < rofs_pkg::NUM_CH; i++) begin
         status[rofs_pkg::STAT_STATE_POS + 2*i +: 2] = r_reg.st[i];
      end

      if (s_axi_awvalid && s_axi_awready) begin
         r_next.awtaken = 1'b1;
         r_next.awaddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         r_next.wtaken = 1'b1;
         r_next.wdata = s_axi_wdata;
         r_next.wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (r_reg.awtaken && r_reg.wtaken) begin
         r_next.awtaken = 1'b0;
         r_next.wtaken = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = rofs_pkg::RESP_OKAY;
         case (r_reg.awaddr)
            rofs_pkg::CTRL_OFS: begin
               r_next.ctrl = strb_merge(r_reg.ctrl, r_reg.wdata,
                                        r_reg.wstrb);
            end
            rofs_pkg::HOLD_OFS: begin
               r_next.hold = strb_merge(r_reg.hold, r_reg.wdata,
                                        r_reg.wstrb);
            end
            rofs_pkg::IRQ_MASK_OFS: begin
               if (r_reg.wstrb[0]) begin
                  r_next.irq_mask = r_reg.wdata[7:0];
               end
            end
            // Status words are read-only; writes to them are dropped
            rofs_pkg::STATUS_OFS, rofs_pkg::IRQ_STAT_OFS: begin
            end
            default: begin
               r_next.bresp = rofs_pkg::RESP_SLVERR;
            end
         endcase
      end

      if (s_axi_rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         r_next.rvalid = 1'b1;
         r_next.rresp = rofs_pkg::RESP_OKAY;
         case (s_axi_araddr[7:0])
            rofs_pkg::CTRL_OFS: r_next.rdata = r_reg.ctrl;
            rofs_pkg::HOLD_OFS: r_next.rdata = r_reg.hold;
            rofs_pkg::STATUS_OFS: r_next.rdata = status;
            rofs_pkg::IRQ_STAT_OFS: begin
               r_next.rdata = {24'h00_0000, r_reg.irq_stat};
               rd_clear = 1'b1;
            end
            rofs_pkg::IRQ_MASK_OFS: begin
               r_next.rdata = {24'h00_0000, r_reg.irq_mask};
            end
            default: begin
               r_next.rdata = 32'h0000_0000;
               r_next.rresp = rofs_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Channel failsafe state
      r_next.link_lost = !link_up_i;
      ev[rofs_pkg::IRQ_LOST_POS] = !link_up_i && !r_reg.link_lost;
      ev[rofs_pkg::IRQ_BACK_POS] = link_up_i && r_reg.link_lost;
      for (int i = 0; i < rofs_pkg::NUM_CH; i++) begin
         ev[rofs_pkg::IRQ_EXPIRE_POS + i] = expired[i];
         case (r_reg.st[i])
            rofs_pkg::CH_NORMAL: begin
               if (!link_up_i) begin
                  r_next.st[i] = rofs_pkg::CH_FAULT;
                  r_next.held[i] = r_reg.relay[i];
                  start[i] = 1'b1;
               end else if (!run_mode_i) begin
                  r_next.st[i] = rofs_pkg::CH_PROGRAM;
                  r_next.held[i] = r_reg.relay[i];
               end
            end
            rofs_pkg::CH_PROGRAM: begin
               if (!link_up_i) begin
                  if (program_fault_escalate[i]) begin
                     r_next.st[i] = rofs_pkg::CH_FAULT;
                     r_next.held[i] = r_reg.relay[i];
                     start[i] = 1'b1;
                  end
               end else if (run_mode_i) begin
                  r_next.st[i] = rofs_pkg::CH_NORMAL;
               end
            end
            rofs_pkg::CH_FAULT, rofs_pkg::CH_FINAL: begin
               if (link_up_i && run_mode_i) begin
                  r_next.st[i] = rofs_pkg::CH_NORMAL;
               end else if (link_up_i) begin
                  r_next.st[i] = rofs_pkg::CH_PROGRAM;
                  r_next.held[i] = r_reg.relay[i];
               end else if (expired[i] &&
                            r_reg.st[i] == rofs_pkg::CH_FAULT) begin
                  r_next.st[i] = rofs_pkg::CH_FINAL;
               end
            end
            default: begin
               r_next.st[i] = rofs_pkg::CH_NORMAL;
            end
         endcase
         case (r_next.st[i])
            rofs_pkg::CH_NORMAL: r_next.relay[i] = out_data_i[i];
            rofs_pkg::CH_PROGRAM: begin
               r_next.relay[i] = program_action_select[i] ?
                  program_output_level[i] : r_next.held[i];
            end
            rofs_pkg::CH_FAULT: begin
               r_next.relay[i] = fault_action_select[i] ?
                  fault_output_level[i] : r_next.held[i];
            end
            rofs_pkg::CH_FINAL: r_next.relay[i] = fault_final_level[i];
            default: r_next.relay[i] = 1'b0;
         endcase
      end
      // A new event wins over the clear by the same read
      r_next.irq_stat = (rd_clear ? 8'h00 : r_reg.irq_stat) | ev;
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r_reg <= '0;
         r_reg.ctrl <= rofs_pkg::CTRL_RESET;
         r_reg.hold <= rofs_pkg::HOLD_RESET;
         r_reg.irq_stat <= rofs_pkg::IRQ_RESET;
         r_reg.irq_mask <= rofs_pkg::IRQ_RESET;
         r_reg.link_lost <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ------------------------------------------------------------------
   // Hold timers
   // ------------------------------------------------------------------
   generate
      for (genvar g = 0; g < rofs_pkg::NUM_CH; g++) begin : g_timer
         rofs_hold_timer #(
            .TICKS_PER_SEC(TICKS_PER_SEC)
         ) u_timer (
            .ref_clk_i(ref_clk_i),
            .reset_n_i(reset_n_i),
            .start_i(start[g]),
            .run_i(r_reg.st[g] == rofs_pkg::CH_FAULT),
            .secs_i(r_reg.hold[8*g +: 8]),
            .expired_o(expired[g])
         );
      end
   endgenerate

   assign relay_o = r_reg.relay;
   assign link_lost_flag_o = r_reg.link_lost;
   assign irq_o = |(r_reg.irq_stat & r_reg.irq_mask);
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;

   // ------------------------------------------------------------------
   // Assertions (channel 0 stands for all)
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence normal_link_drop;
      r_reg.st[0] == rofs_pkg::CH_NORMAL ##0 !link_up_i;
   endsequence

   sequence enter_fault_latched;
      r_reg.st[0] == rofs_pkg::CH_FAULT ##0
         r_reg.held[0] == $past(r_reg.relay[0]);
   endsequence

   fault_hold_a: assert property (
      normal_link_drop ##0 !fault_action_select[0] |=>
         relay_o[0] == $past(relay_o[0]))
      else $error("fault hold-last changed the output");

   fault_latch_a: assert property (
      normal_link_drop |=> enter_fault_latched)
      else $error("fault entry did not latch the driven level");

   fault_level_a: assert property (
      r_reg.st[0] == rofs_pkg::CH_FAULT && $past(fault_action_select[0])
      |-> relay_o[0] == $past(fault_output_level[0]))
      else $error("fault level not driven");

   prog_hold_a: assert property (
      r_reg.st[0] == rofs_pkg::CH_PROGRAM &&
      $past(r_reg.st[0]) == rofs_pkg::CH_PROGRAM &&
      !$past(program_action_select[0]) |-> $stable(relay_o[0]))
      else $error("program hold-last changed the output");

   prog_level_a: assert property (
      r_reg.st[0] == rofs_pkg::CH_PROGRAM &&
      $past(program_action_select[0])
      |-> relay_o[0] == $past(program_output_level[0]))
      else $error("program level not driven");

   hold_forever_a: assert property (
      r_reg.st[0] == rofs_pkg::CH_FAULT && r_reg.hold[7:0] == 8'h00 &&
      !link_up_i |=> r_reg.st[0] == rofs_pkg::CH_FAULT)
      else $error("zero hold time left the fault level");

   final_level_a: assert property (
      expired[0] && r_reg.st[0] == rofs_pkg::CH_FAULT && !link_up_i
      |=> r_reg.st[0] == rofs_pkg::CH_FINAL ##0
          relay_o[0] == $past(fault_final_level[0]))
      else $error("final level not applied on expiry");

   escalate_a: assert property (
      r_reg.st[0] == rofs_pkg::CH_PROGRAM && !link_up_i &&
      !program_fault_escalate[0] |=> r_reg.st[0] == rofs_pkg::CH_PROGRAM)
      else $error("program mode escalated without enable");

   link_flag_a: assert property (
      $fell(link_up_i) |=> link_lost_flag_o &&
         r_reg.irq_stat[rofs_pkg::IRQ_LOST_POS])
      else $error("link loss not flagged");

   restore_a: assert property (
      link_up_i && run_mode_i |=> r_reg.st[0] == rofs_pkg::CH_NORMAL &&
         relay_o[0] == $past(out_data_i[0]) && !link_lost_flag_o)
      else $error("run mode did not resume normal data");

endmodule

/* rofs_owner_model.sv */
`timescale 1ns/1ps
module rofs_owner_model (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic cmd_link_i,
   input wire logic cmd_run_i,
   input wire logic [3:0] cmd_data_i,
   output logic link_up_o,
   output logic run_mode_o,
   output logic [3:0] out_data_o
);
   // -----------------------------------------------------------------
   // Owner side, updated once per edge like the network logic
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_up_o <= 1'b0;
         run_mode_o <= 1'b0;
         out_data_o <= 4'h0;
      end else begin
         link_up_o <= cmd_link_i;
         run_mode_o <= cmd_run_i;
         // Data is only meaningful while the link runs
         out_data_o <= cmd_link_i ? cmd_data_i : ~out_data_o;
      end
   end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   localparam int TICKS = 8;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic cmd_link = 1'b0;
   logic cmd_run = 1'b0;
   logic [3:0] cmd_data = 4'h0;
   logic link_up, run_mode, lost, irq;
   logic [3:0] out_data, relay;
   logic [31:0] awaddr = 32'h0000_0000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] araddr = 32'h0000_0000;
   logic [31:0] rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int err_total = 0;
   int cmp_count = 0;

   always #12.5 ref_clk_i = ~ref_clk_i;

   rofs_owner_model owner (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .cmd_link_i(cmd_link), .cmd_run_i(cmd_run), .cmd_data_i(cmd_data),
      .link_up_o(link_up), .run_mode_o(run_mode), .out_data_o(out_data));

   rofs_failsafe #(.TICKS_PER_SEC(TICKS)) uut (.ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i), .link_up_i(link_up), .run_mode_i(run_mode),
      .out_data_i(out_data), .relay_o(relay), .link_lost_flag_o(lost),
      .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // -----------------------------------------------------------------
   // Checking and closing
   // -----------------------------------------------------------------
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic timed_out(input string what);
      err_total++;
      $display("CHECK FAILED at %0t: no answer for %s", $time, what);
      summarize();
   endtask

   // -----------------------------------------------------------------
   // Register bus master
   // -----------------------------------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] exp_resp);
      logic a_hit, w_hit, b_hit;
      logic [1:0] br;
      int n;
      @(posedge ref_clk_i);
      awaddr <= {24'h00_0000, a};
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_hit = 1'b0;
      for (n = 0; n < 50 && !b_hit; n++) begin
         @(negedge ref_clk_i);
         a_hit = awvalid && awready;
         w_hit = wvalid && wready;
         b_hit = bvalid;
         br = bresp;
         @(posedge ref_clk_i);
         if (a_hit)
            awvalid <= 1'b0;
         if (w_hit)
            wvalid <= 1'b0;
         if (b_hit) begin
            bready <= 1'b0;
            check_val({30'h0, br}, {30'h0, exp_resp}, "write response");
         end
      end
      if (!b_hit)
         timed_out("write");
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
                           input logic [1:0] exp_resp);
      logic ar_hit, r_hit;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      @(posedge ref_clk_i);
      araddr <= {24'h00_0000, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_hit = 1'b0;
      for (n = 0; n < 50 && !r_hit; n++) begin
         @(negedge ref_clk_i);
         ar_hit = arvalid && arready;
         r_hit = rvalid;
         d = rdata;
         r = rresp;
         @(posedge ref_clk_i);
         if (ar_hit)
            arvalid <= 1'b0;
         if (r_hit)
            rready <= 1'b0;
      end
      if (!r_hit)
         timed_out("read");
      check_val(d, exp, "read data");
      check_val({30'h0, r}, {30'h0, exp_resp}, "read response");
   endtask

   // Owner command reaches the relays two edges later
   task automatic owner_set(input logic l, input logic rm, input logic [3:0] d);
      @(posedge ref_clk_i);
      cmd_link <= l;
      cmd_run <= rm;
      cmd_data <= d;
      repeat (2) @(posedge ref_clk_i);
      #1;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic sc_reset_values();
      check_val({31'h0, lost}, 32'h0000_0001, "flag after reset");
      check_val({28'h0, relay}, 32'h0000_0000, "relay after reset");
      axi_read(rofs_pkg::CTRL_OFS, 32'h0000_0000, rofs_pkg::RESP_OKAY);
      axi_read(rofs_pkg::HOLD_OFS, 32'h0000_0000, rofs_pkg::RESP_OKAY);
      axi_read(rofs_pkg::IRQ_MASK_OFS, 32'h0000_0000, rofs_pkg::RESP_OKAY);
      axi_read(8'h20, 32'h0000_0000, rofs_pkg::RESP_SLVERR);
      axi_write(8'h24, 32'hFFFF_FFFF, rofs_pkg::RESP_SLVERR);
   endtask

   task automatic sc_normal_run();
      owner_set(1'b1, 1'b1, 4'hA);
      check_val({31'h0, lost}, 32'h0000_0000, "flag while linked");
      check_val({28'h0, relay}, 32'h0000_000A, "normal data");
      owner_set(1'b1, 1'b1, 4'h5);
      check_val({28'h0, relay}, 32'h0000_0005, "data follows");
      owner_set(1'b1, 1'b1, 4'hA);
      axi_read(rofs_pkg::IRQ_STAT_OFS, 32'h0000_0002, rofs_pkg::RESP_OKAY);
   endtask

   task automatic sc_fault_timed();
      int n;
      axi_write(rofs_pkg::CTRL_OFS, 32'h0000_0013, rofs_pkg::RESP_OKAY);
      axi_write(rofs_pkg::HOLD_OFS, 32'h0000_0005, rofs_pkg::RESP_OKAY);
      axi_write(rofs_pkg::IRQ_MASK_OFS, 32'h0000_0001, rofs_pkg::RESP_OKAY);
      owner_set(1'b0, 1'b1, 4'hA);
      // Ch0 fault on, ch1 fault off, ch2/ch3 keep 0 and 1
      check_val({28'h0, relay}, 32'h0000_0009, "fault levels");
      check_val({31'h0, lost}, 32'h0000_0001, "flag on loss");
      check_val({31'h0, irq}, 32'h0000_0001, "irq on loss");
      axi_read(rofs_pkg::STATUS_OFS, 32'h0009_0551, rofs_pkg::RESP_OKAY);
      axi_read(rofs_pkg::IRQ_STAT_OFS, 32'h0000_0001, rofs_pkg::RESP_OKAY);
      #1;
      check_val({31'h0, irq}, 32'h0000_0000, "irq after clear");
      check_val({28'h0, relay}, 32'h0000_0009, "still fault level");
      for (n = 0; n < 80 && relay !== 4'h8; n++) begin
         @(posedge ref_clk_i);
         #1;
      end
      if (relay !== 4'h8)
         timed_out("hold expiry");
      #1;
      check_val({28'h0, relay}, 32'h0000_0008, "final level");
      repeat (3 * TICKS) @(posedge ref_clk_i);
      #1;
      check_val({28'h0, relay}, 32'h0000_0008, "zero hold keeps");
      axi_read(rofs_pkg::IRQ_STAT_OFS, 32'h0000_0010, rofs_pkg::RESP_OKAY);
   endtask

   task automatic sc_restore();
      owner_set(1'b1, 1'b1, 4'h6);
      check_val({28'h0, relay}, 32'h0000_0006, "restored data");
      check_val({31'h0, lost}, 32'h0000_0000, "flag restored");
   endtask

   task automatic sc_program();
      axi_write(rofs_pkg::HOLD_OFS, 32'h0000_0000, rofs_pkg::RESP_OKAY);
      axi_write(rofs_pkg::CTRL_OFS, 32'h0021_1122, rofs_pkg::RESP_OKAY);
      owner_set(1'b1, 1'b1, 4'h4);
      owner_set(1'b1, 1'b0, 4'hB);
      // Ch0 program on, others keep their last level
      check_val({28'h0, relay}, 32'h0000_0005, "program levels");
      repeat (20) @(posedge ref_clk_i);
      #1;
      check_val({28'h0, relay}, 32'h0000_0005, "program held");
      owner_set(1'b0, 1'b0, 4'hB);
      // Ch1 escalates to its fault level, ch0 stays in program
      check_val({28'h0, relay}, 32'h0000_0007, "escalation");
      axi_read(rofs_pkg::STATUS_OFS, 32'h0007_0A61, rofs_pkg::RESP_OKAY);
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      sc_reset_values();
      sc_normal_run();
      sc_fault_timed();
      sc_restore();
      sc_program();
      summarize();
   end
endmodule
